// ---- core/tgo_gain_regs.sv ----
// Transmit gain, trim and offset register slice with shared gain update control
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: Per-channel direction bit: clear puts offset on negative output, set on positive.
// RULE2: Gain register bits 7:6 hold each channel's two-bit coarse scale field.
// RULE3: Coarse code 00 is one eleventh, 01 one half, 10 and 11 full.
// RULE4: Gain register bits 5:0 are a six-bit twos complement fine trim.
// RULE5: Fine trim sense is inverted: adjustment is the negated code.
// RULE6: Shared amplifier gain is eight-bit straight binary, driving both channels.
// RULE7: Amplifier code spans minus 20 dB at zeros to 0 dB at ones.
// RULE8: Shared amplifier gain register resets to all ones.
// RULE9: Without slave mode a written gain applies right after the write.
// RULE10: In slave mode the gain waits for a power-down pin falling edge.
// RULE11: Offset is ten bits: nine magnitude bits, top bit add when set.
// RULE12: Control bit 4 picks fast settling; clear gives a smooth ramp.
module tgo_gain_regs #(
    parameter int RAMP_DIV = tgo_pkg::RAMP_DIV_DEFAULT
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic csb_in,
    input wire logic sdio_in,
    input wire logic tx_power_down_pin_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic [7:0] tx_shared_gain_amp_out,
    output logic gain_fast_settle_select_out,
    output logic gain_update_slave_mode_out,
    output logic [1:0] coarse_scale_a_out,
    output logic [1:0] coarse_scale_b_out,
    output logic [6:0] fine_adjust_a_out,
    output logic [6:0] fine_adjust_b_out,
    output logic [8:0] offset_mag_a_out,
    output logic [8:0] offset_mag_b_out,
    output logic offset_add_a_out,
    output logic offset_add_b_out,
    output logic offset_pos_pin_a_out,
    output logic offset_pos_pin_b_out
);
    typedef struct packed {
        logic [1:0][7:0] gain_trim;
        logic [1:0][7:0] off_hi;
        logic [1:0][7:0] off_lo;
        logic [7:0] amp;
        logic [7:0] ctrl;
        logic [7:0] target;
        logic [7:0] applied;
        logic pwd_q;
        logic [15:0] div;
        logic [7:0] rd_data;
        logic [1:0][1:0] coarse;
        logic [1:0][6:0] fine;
        logic [1:0][8:0] mag;
        logic [1:0] add;
        logic [1:0] dir;
    } tgo_regs_s;

    tgo_regs_s st;
    tgo_regs_s next_st;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic sp_sdo;
    logic sp_oe;
    logic tick;
    logic pwd_fall;

    tgo_serial_port u_port (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .sclk_in(sclk_in),
        .csb_in(csb_in),
        .sdio_in(sdio_in),
        .rd_data_in(st.rd_data),
        .addr_out(addr),
        .wr_data_out(wdata),
        .wr_pulse_out(wr),
        .sdo_out(sp_sdo),
        .sdo_oe_out(sp_oe)
    );

    assign tick = st.div == 16'h0000;
    assign pwd_fall = st.pwd_q && !tx_power_down_pin_in;

    always_comb begin
        next_st = st;
        next_st.pwd_q = tx_power_down_pin_in;
        next_st.div = tick ? 16'(RAMP_DIV - 1) : st.div - 16'h0001;
        if (wr) begin
            case (addr)
                tgo_pkg::ADDR_CHAN_A_GAIN_TRIM: next_st.gain_trim[0] = wdata;
                tgo_pkg::ADDR_CHAN_B_GAIN_TRIM: next_st.gain_trim[1] = wdata;
                tgo_pkg::ADDR_OFFSET_A_HI: next_st.off_hi[0] = wdata;
                tgo_pkg::ADDR_OFFSET_A_LO: next_st.off_lo[0] = wdata;
                tgo_pkg::ADDR_OFFSET_B_HI: next_st.off_hi[1] = wdata;
                tgo_pkg::ADDR_OFFSET_B_LO: next_st.off_lo[1] = wdata;
                tgo_pkg::ADDR_TX_GAIN_UPDATE_CONTROL: next_st.ctrl = wdata;
                tgo_pkg::ADDR_SHARED_AMP_GAIN: begin
                    next_st.amp = wdata; // RULE6
                    if (!st.ctrl[tgo_pkg::SLAVE_MODE_BIT]) begin
                        next_st.target = wdata; // RULE9
                    end
                end
                default: begin
                end
            endcase
        end
        // Pending gain taken at wake-up edge
        if (st.ctrl[tgo_pkg::SLAVE_MODE_BIT] && pwd_fall) begin
            next_st.target = st.amp; // RULE10
        end
        // Fast jump or one code per tick
        if (st.ctrl[tgo_pkg::FAST_SETTLE_BIT]) begin
            next_st.applied = st.target; // RULE12
        end else if (tick && st.applied < st.target) begin
            next_st.applied = st.applied + 8'h01; // RULE12
        end else if (tick && st.applied > st.target) begin
            next_st.applied = st.applied - 8'h01; // RULE12
        end
        case (addr)
            tgo_pkg::ADDR_CHAN_A_GAIN_TRIM: next_st.rd_data = st.gain_trim[0];
            tgo_pkg::ADDR_CHAN_B_GAIN_TRIM: next_st.rd_data = st.gain_trim[1];
            tgo_pkg::ADDR_OFFSET_A_HI: next_st.rd_data = st.off_hi[0];
            tgo_pkg::ADDR_OFFSET_A_LO: next_st.rd_data = st.off_lo[0];
            tgo_pkg::ADDR_OFFSET_B_HI: next_st.rd_data = st.off_hi[1];
            tgo_pkg::ADDR_OFFSET_B_LO: next_st.rd_data = st.off_lo[1];
            tgo_pkg::ADDR_SHARED_AMP_GAIN: next_st.rd_data = st.amp;
            tgo_pkg::ADDR_TX_GAIN_UPDATE_CONTROL: next_st.rd_data = st.ctrl;
            default: next_st.rd_data = 8'h00;
        endcase
        for (int i = 0; i < 2; i++) begin
            case (st.gain_trim[i][tgo_pkg::COARSE_MSB:tgo_pkg::COARSE_LSB]) // RULE2
                2'h0: next_st.coarse[i] = tgo_pkg::COARSE_ONE_ELEVENTH; // RULE3
                2'h1: next_st.coarse[i] = tgo_pkg::COARSE_HALF; // RULE3
                default: next_st.coarse[i] = tgo_pkg::COARSE_FULL; // RULE3
            endcase
            // Inverted sense, one extra bit for 100000
            next_st.fine[i] = 7'h00 - {st.gain_trim[i][tgo_pkg::FINE_MSB],
                                       st.gain_trim[i][tgo_pkg::FINE_MSB:0]}; // RULE4 RULE5
            next_st.mag[i] = {st.off_hi[i][6:0], st.off_lo[i][tgo_pkg::OFFSET_LO_MSB:0]}; // RULE11
            next_st.add[i] = st.off_hi[i][7]; // RULE11
            next_st.dir[i] = st.off_lo[i][tgo_pkg::OFFSET_DIR_BIT]; // RULE1
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
            st.gain_trim <= {tgo_pkg::RST_GAIN_TRIM, tgo_pkg::RST_GAIN_TRIM};
            st.off_hi <= {tgo_pkg::RST_OFFSET, tgo_pkg::RST_OFFSET};
            st.off_lo <= {tgo_pkg::RST_OFFSET, tgo_pkg::RST_OFFSET};
            st.amp <= tgo_pkg::RST_SHARED_AMP_GAIN; // RULE8
            st.target <= tgo_pkg::RST_SHARED_AMP_GAIN;
            st.applied <= tgo_pkg::RST_SHARED_AMP_GAIN; // RULE7
            st.ctrl <= tgo_pkg::RST_CONTROL;
            st.coarse <= {tgo_pkg::COARSE_ONE_ELEVENTH, tgo_pkg::COARSE_ONE_ELEVENTH};
        end else begin
            st <= next_st;
        end
    end

    assign sdo_out = sp_sdo;
    assign sdo_oe_out = sp_oe;
    assign tx_shared_gain_amp_out = st.applied;
    assign gain_fast_settle_select_out = st.ctrl[tgo_pkg::FAST_SETTLE_BIT];
    assign gain_update_slave_mode_out = st.ctrl[tgo_pkg::SLAVE_MODE_BIT];
    assign coarse_scale_a_out = st.coarse[0];
    assign coarse_scale_b_out = st.coarse[1];
    assign fine_adjust_a_out = st.fine[0];
    assign fine_adjust_b_out = st.fine[1];
    assign offset_mag_a_out = st.mag[0];
    assign offset_mag_b_out = st.mag[1];
    assign offset_add_a_out = st.add[0];
    assign offset_add_b_out = st.add[1];
    assign offset_pos_pin_a_out = st.dir[0];
    assign offset_pos_pin_b_out = st.dir[1];

    sequence amp_write_s;
        wr && addr == tgo_pkg::ADDR_SHARED_AMP_GAIN;
    endsequence

    sequence wake_edge_s;
        st.ctrl[tgo_pkg::SLAVE_MODE_BIT] && pwd_fall;
    endsequence

    chk_amp_reset: assert property (@(posedge clock_in) // RULE8
        $rose(nrst_in) |-> st.amp == 8'hff && tx_shared_gain_amp_out == 8'hff)
        else $error("amp gain not all ones after reset");
    chk_immediate_update: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE9
        amp_write_s ##0 !st.ctrl[tgo_pkg::SLAVE_MODE_BIT] |=> st.target == $past(wdata))
        else $error("gain write not applied immediately");
    chk_slave_hold: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE10
        st.ctrl[tgo_pkg::SLAVE_MODE_BIT] && !pwd_fall |=> st.target == $past(st.target))
        else $error("slave gain changed without wake edge");
    chk_slave_apply: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE10
        wake_edge_s |=> st.target == $past(st.amp))
        else $error("pending gain not taken at wake edge");
    chk_fast_settle: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        st.ctrl[tgo_pkg::FAST_SETTLE_BIT] |=> tx_shared_gain_amp_out == $past(st.target))
        else $error("fast mode did not settle in one cycle");
    chk_smooth_step: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        !st.ctrl[tgo_pkg::FAST_SETTLE_BIT] && st.applied < st.target && tick
        |=> tx_shared_gain_amp_out == $past(st.applied) + 8'h01)
        else $error("smooth ramp step wrong");
    chk_coarse_decode: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE3
        st.gain_trim[0][7:6] == 2'h1 |=> coarse_scale_a_out == tgo_pkg::COARSE_HALF)
        else $error("coarse half code misdecoded");
    chk_fine_invert: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE5
        1'b1 |=> $signed(fine_adjust_b_out) == -$signed({$past(st.gain_trim[1][5]),
                                                         $past(st.gain_trim[1][5:0])}))
        else $error("fine trim sense not inverted");
    chk_offset_dir: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE1
        1'b1 |=> offset_pos_pin_a_out == $past(st.off_lo[0][7])
                 && offset_add_a_out == $past(st.off_hi[0][7]))
        else $error("offset direction or sign wrong");

    sequence ctrl_write_s;
        wr && addr == tgo_pkg::ADDR_TX_GAIN_UPDATE_CONTROL;
    endsequence

    sequence smooth_tick_s;
        !st.ctrl[tgo_pkg::FAST_SETTLE_BIT] && tick;
    endsequence

    chk_amp_lands: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE6
        amp_write_s |=> st.amp == $past(wdata))
        else $error("amp gain write lost");
    chk_amp_holds: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE6
        !(wr && addr == tgo_pkg::ADDR_SHARED_AMP_GAIN) |=> st.amp == $past(st.amp))
        else $error("amp gain changed without write");
    chk_ctrl_lands: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        ctrl_write_s |=> st.ctrl == $past(wdata))
        else $error("control write lost");
    chk_slave_pending: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE10
        amp_write_s ##0 st.ctrl[tgo_pkg::SLAVE_MODE_BIT] && !pwd_fall
        |=> st.amp == $past(wdata) && st.target == $past(st.target))
        else $error("slave write not held pending");
    chk_target_quiet: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE9
        !(wr && addr == tgo_pkg::ADDR_SHARED_AMP_GAIN) && !pwd_fall
        |=> st.target == $past(st.target))
        else $error("gain target moved without cause");
    chk_smooth_down: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        smooth_tick_s ##0 st.applied > st.target
        |=> tx_shared_gain_amp_out == $past(st.applied) - 8'h01)
        else $error("smooth ramp down step wrong");
    chk_smooth_wait: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        !st.ctrl[tgo_pkg::FAST_SETTLE_BIT] && !tick
        |=> tx_shared_gain_amp_out == $past(tx_shared_gain_amp_out))
        else $error("smooth ramp moved between ticks");
    chk_smooth_rest: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        !st.ctrl[tgo_pkg::FAST_SETTLE_BIT] && st.applied == st.target
        |=> tx_shared_gain_amp_out == $past(st.applied))
        else $error("settled gain moved");
    chk_ramp_reload: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        tick |=> st.div == 16'(RAMP_DIV - 1))
        else $error("ramp divider reload wrong");
    chk_read_amp: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE8
        addr == tgo_pkg::ADDR_SHARED_AMP_GAIN |=> st.rd_data == $past(st.amp))
        else $error("amp gain read data wrong");
    chk_read_ctrl: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE12
        addr == tgo_pkg::ADDR_TX_GAIN_UPDATE_CONTROL |=> st.rd_data == $past(st.ctrl))
        else $error("control read data wrong");

    // Per-channel write, decode and read checks
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan_chk
        localparam logic [6:0] TRIM_ADDR = ch == 0 ? tgo_pkg::ADDR_CHAN_A_GAIN_TRIM
            : tgo_pkg::ADDR_CHAN_B_GAIN_TRIM;
        localparam logic [6:0] HI_ADDR = ch == 0 ? tgo_pkg::ADDR_OFFSET_A_HI
            : tgo_pkg::ADDR_OFFSET_B_HI;
        localparam logic [6:0] LO_ADDR = ch == 0 ? tgo_pkg::ADDR_OFFSET_A_LO
            : tgo_pkg::ADDR_OFFSET_B_LO;

        chk_trim_lands: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE2
            wr && addr == TRIM_ADDR |=> st.gain_trim[ch] == $past(wdata))
            else $error("gain trim write lost");
        chk_offset_lands: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE11
            wr && addr == HI_ADDR |=> st.off_hi[ch] == $past(wdata))
            else $error("offset high write lost");
        chk_dir_lands: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE1
            wr && addr == LO_ADDR |=> st.off_lo[ch] == $past(wdata))
            else $error("offset low write lost");
        chk_coarse_map: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE3
            1'b1 |=> st.coarse[ch] == ($past(st.gain_trim[ch][tgo_pkg::COARSE_MSB])
                ? tgo_pkg::COARSE_FULL : $past(st.gain_trim[ch][tgo_pkg::COARSE_LSB])
                ? tgo_pkg::COARSE_HALF : tgo_pkg::COARSE_ONE_ELEVENTH))
            else $error("coarse scale misdecoded");
        chk_fine_sign: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE4
            1'b1 |=> $signed(st.fine[ch]) == -$signed({$past(st.gain_trim[ch][5]),
                                                       $past(st.gain_trim[ch][5:0])}))
            else $error("fine trim misdecoded");
        chk_offset_map: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE11
            1'b1 |=> st.mag[ch] == {$past(st.off_hi[ch][6:0]), $past(st.off_lo[ch][1:0])}
                     && st.add[ch] == $past(st.off_hi[ch][7]))
            else $error("offset magnitude or sign wrong");
        chk_dir_map: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE1
            1'b1 |=> st.dir[ch] == $past(st.off_lo[ch][tgo_pkg::OFFSET_DIR_BIT]))
            else $error("offset direction wrong");
        chk_read_trim: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE2
            addr == TRIM_ADDR |=> st.rd_data == $past(st.gain_trim[ch]))
            else $error("gain trim read data wrong");
    end
endmodule
`default_nettype wire

// ---- core/tgo_pkg.sv ----
// Package of register map, field layout and reset values for the transmit gain slice
package tgo_pkg;
    localparam logic [6:0] ADDR_OFFSET_A_HI = 7'h0b;
    localparam logic [6:0] ADDR_OFFSET_A_LO = 7'h0c;
    localparam logic [6:0] ADDR_CHAN_A_GAIN_TRIM = 7'h0d;
    localparam logic [6:0] ADDR_OFFSET_B_HI = 7'h0e;
    localparam logic [6:0] ADDR_OFFSET_B_LO = 7'h0f;
    localparam logic [6:0] ADDR_CHAN_B_GAIN_TRIM = 7'h10;
    localparam logic [6:0] ADDR_SHARED_AMP_GAIN = 7'h11;
    localparam logic [6:0] ADDR_TX_GAIN_UPDATE_CONTROL = 7'h12;
    localparam int COARSE_MSB = 7;
    localparam int COARSE_LSB = 6;
    localparam int FINE_MSB = 5;
    localparam int OFFSET_DIR_BIT = 7;
    localparam int OFFSET_LO_MSB = 1;
    localparam int SLAVE_MODE_BIT = 6;
    localparam int FAST_SETTLE_BIT = 4;
    localparam logic [7:0] RST_GAIN_TRIM = 8'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_SHARED_AMP_GAIN = 8'hff;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [1:0] COARSE_ONE_ELEVENTH = 2'h0;
    localparam logic [1:0] COARSE_HALF = 2'h1;
    localparam logic [1:0] COARSE_FULL = 2'h2;
    localparam int FRAME_BITS = 16;
    localparam int RAMP_DIV_DEFAULT = 64;
endpackage

// ---- core/tgo_serial_port.sv ----
// Serial configuration port slave: read/write flag, 7-bit address, 8-bit data, MSB first
`timescale 1ns/1ps
`default_nettype none
module tgo_serial_port (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic csb_in,
    input wire logic sdio_in,
    input wire logic [7:0] rd_data_in,
    output logic [6:0] addr_out,
    output logic [7:0] wr_data_out,
    output logic wr_pulse_out,
    output logic sdo_out,
    output logic sdo_oe_out
);
    typedef struct packed {
        logic sclk_q;
        logic rd;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [7:0] rd_sh;
        logic sdo;
        logic oe;
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } tgo_sp_s;

    tgo_sp_s st;
    tgo_sp_s next_st;

    always_comb begin
        next_st = st;
        next_st.sclk_q = sclk_in;
        next_st.wr = 1'b0;
        if (csb_in) begin
            next_st.cnt = 5'h00;
            next_st.oe = 1'b0;
        end else if (sclk_in && !st.sclk_q && st.cnt < 5'(tgo_pkg::FRAME_BITS)) begin
            // Sample on rising serial clock
            next_st.sh = {st.sh[14:0], sdio_in};
            next_st.cnt = st.cnt + 5'h01;
            // First bit of the frame marks a read
            if (st.cnt == 5'h00) begin
                next_st.rd = sdio_in;
            end
            if (st.cnt == 5'h07) begin
                next_st.addr = {st.sh[5:0], sdio_in};
            end
            if (st.cnt == 5'(tgo_pkg::FRAME_BITS - 1) && !st.sh[14]) begin
                next_st.data = {st.sh[6:0], sdio_in};
                next_st.wr = 1'b1;
            end
        end else if (!sclk_in && st.sclk_q && st.rd && st.cnt >= 5'h08) begin
            // Read data shifts out on falling serial clock
            if (st.cnt == 5'h08) begin
                next_st.sdo = rd_data_in[7];
                next_st.rd_sh = {rd_data_in[6:0], 1'b0};
            end else begin
                next_st.sdo = st.rd_sh[7];
                next_st.rd_sh = {st.rd_sh[6:0], 1'b0};
            end
            next_st.oe = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign addr_out = st.addr;
    assign wr_data_out = st.data;
    assign wr_pulse_out = st.wr;
    assign sdo_out = st.sdo;
    assign sdo_oe_out = st.oe;
endmodule
`default_nettype wire

// ---- dv/tgo_host_model.sv ----
// Serial configuration host model that sends frames into the gain slice
`timescale 1ns/1ps
`default_nettype none
module tgo_host_model (
    input wire logic clock_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic sclk_out,
    output logic csb_out,
    output logic sdio_out
);
    initial begin
        sclk_out = 1'b0;
        csb_out = 1'b1;
        sdio_out = 1'b0;
    end
    // One frame, serial clock high for two cycles and low for three, sdo sampled on rise
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [15:0] w;
        w = {rw, a, d};
        q = 8'h00;
        @(posedge clock_in) csb_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clock_in) sdio_out <= w[i];
            @(posedge clock_in);
            @(posedge clock_in) sclk_out <= 1'b1;
            if (i < 8) q[i] = sdo_oe_in ? sdo_in : !sdo_in;
            repeat (2) @(posedge clock_in);
            sclk_out <= 1'b0;
        end
        @(posedge clock_in) csb_out <= 1'b1;
        // Released data line shows no stale value
        sdio_out <= ~sdio_out;
        repeat (3) @(posedge clock_in);
    endtask
endmodule
`default_nettype wire

// ---- dv/tx_gain_offset_control_regs_tb.sv ----
// Self-checking bench for the transmit gain and offset slice
`timescale 1ns/1ps
`default_nettype none
module tx_gain_offset_control_regs_tb;
    typedef struct packed {
        logic [6:0] a;
        logic [7:0] d;
        logic [10:0] e;
    } tgo_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pwd = 1'b0;
    logic sclk, csb, sdio, sdo, oe, fast, slave, add_a, add_b, pos_a, pos_b;
    logic [7:0] gain, q;
    logic [1:0] crs_a, crs_b;
    logic [6:0] fin_a, fin_b;
    logic [8:0] mag_a, mag_b;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    tgo_row_s rows [15];
    logic [6:0] rst_addr [6] = '{7'h0d, 7'h10, 7'h0b, 7'h0e, 7'h11, 7'h12};

    tgo_gain_regs #(.RAMP_DIV(2)) dut_u (.clock_in(clk), .nrst_in(nrst), .sclk_in(sclk),
        .csb_in(csb), .sdio_in(sdio), .tx_power_down_pin_in(pwd), .sdo_out(sdo),
        .sdo_oe_out(oe), .tx_shared_gain_amp_out(gain), .gain_fast_settle_select_out(fast),
        .gain_update_slave_mode_out(slave), .coarse_scale_a_out(crs_a),
        .coarse_scale_b_out(crs_b), .fine_adjust_a_out(fin_a), .fine_adjust_b_out(fin_b),
        .offset_mag_a_out(mag_a), .offset_mag_b_out(mag_b), .offset_add_a_out(add_a),
        .offset_add_b_out(add_b), .offset_pos_pin_a_out(pos_a),
        .offset_pos_pin_b_out(pos_b));
    tgo_host_model host_u (.clock_in(clk), .sdo_in(sdo), .sdo_oe_in(oe), .sclk_out(sclk),
        .csb_out(csb), .sdio_out(sdio));

    always #2 clk = ~clk;

    task automatic test_done();
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [6:0] a);
        host_u.xfer(1'b1, a, 8'h00, q);
    endtask

    // Decoded outputs that belong to one register address
    function automatic logic [10:0] obs(input logic [6:0] a);
        case (a)
            7'h0d: obs = {2'h0, crs_a, fin_a};
            7'h10: obs = {2'h0, crs_b, fin_b};
            7'h0b, 7'h0c: obs = {add_a, mag_a, pos_a};
            7'h0e, 7'h0f: obs = {add_b, mag_b, pos_b};
            7'h11: obs = {3'h0, gain};
            default: obs = {9'h0, slave, fast};
        endcase
    endfunction

    initial begin
        rows = '{'{7'h0d, 8'h20, 11'h020}, '{7'h0d, 8'h7f, 11'h081}, '{7'h0d, 8'h81, 11'h17f},
            '{7'h0d, 8'hdf, 11'h161}, '{7'h10, 8'h5f, 11'h0e1}, '{7'h10, 8'h00, 11'h000},
            '{7'h0b, 8'h81, 11'h408}, '{7'h0c, 8'h83, 11'h40f}, '{7'h0b, 8'h7f, 11'h3ff},
            '{7'h0e, 8'hff, 11'h7f8}, '{7'h0f, 8'h01, 11'h7fa}, '{7'h0f, 8'h80, 11'h7f9},
            '{7'h12, 8'h10, 11'h001}, '{7'h11, 8'h00, 11'h000}, '{7'h11, 8'h80, 11'h080}};
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (rst_addr[i]) begin
            rd(rst_addr[i]);
            check({3'h0, q}, (rst_addr[i] == 7'h11) ? 11'h0ff : 11'h000);
            check(obs(rst_addr[i]), (rst_addr[i] == 7'h11) ? 11'h0ff : 11'h000);
            check({10'h0, oe}, 11'h000);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            @(posedge clk);
            check(obs(rows[i].a), rows[i].e);
            rd(rows[i].a);
            check({3'h0, q}, {3'h0, rows[i].d});
        end
        // Smooth ramp from 0x80 up to full gain
        wr(7'h12, 8'h00);
        wr(7'h11, 8'hff);
        check({10'h0, gain == 8'hff}, 11'h000);
        for (int n = 0; n < 600 && gain !== 8'hff; n++) @(posedge clk);
        check({3'h0, gain}, 11'h0ff);
        // Held update released by the power-down falling edge
        wr(7'h12, 8'h50);
        check(obs(7'h12), 11'h003);
        wr(7'h11, 8'h10);
        rd(7'h11);
        check({3'h0, q}, 11'h010);
        pwd <= 1'b1;
        repeat (8) @(posedge clk);
        check({3'h0, gain}, 11'h0ff);
        pwd <= 1'b0;
        repeat (8) @(posedge clk);
        check({3'h0, gain}, 11'h010);
        // Unmapped address
        wr(7'h20, 8'h55);
        rd(7'h20);
        check({3'h0, q}, 11'h000);
        rd(7'h11);
        check({3'h0, q}, 11'h010);
        // Second reset in mid-run
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        check({3'h0, gain}, 11'h0ff);
        check(obs(7'h0d), 11'h000);
        nrst <= 1'b1;
        @(posedge clk);
        rd(7'h11);
        check({3'h0, q}, 11'h0ff);
        // Smooth ramp down, fast mode cleared by reset
        wr(7'h11, 8'hf0);
        check({10'h0, gain == 8'hf0}, 11'h000);
        repeat (40) @(posedge clk);
        check({3'h0, gain}, 11'h0f0);
        test_done();
    end
endmodule
`default_nettype wire
